// ---- irq_bank_pkg.sv ----
// package: register map, field positions and reset values of the interrupt bank
`default_nettype none
package irq_bank_pkg;
    // register indices; the byte address on the bus is four times the index
    localparam logic [8:0] FLAGS_ONE_IDX = 9'h012;
    localparam logic [8:0] FLAGS_TWO_IDX = 9'h013;
    localparam logic [8:0] STATUS_IDX = 9'h010;
    localparam logic [8:0] CONTROL_IDX = 9'h011;
    localparam logic [8:0] ENERGY_HIST_IDX = 9'h019;
    localparam logic [8:0] ENERGY_CFG_IDX = 9'h101;
    localparam logic [8:0] RX_ERR_CNT_IDX = 9'h015;
    // field positions
    localparam int FLAG_LSB = 8;
    localparam int NUM_EVENTS = 7;
    localparam int ENERGY_FLAG_BIT = 14;
    localparam int LINK_QUAL_EN_BIT = 7;
    localparam int PIN_SET_BIT = 7;
    localparam int GLOBAL_EN_BIT = 1;
    localparam int POLARITY_BIT = 3;
    localparam int ENERGY_HIST_BIT = 10;
    localparam int RISING_ONLY_BIT = 0;
    // reset values
    localparam logic [15:0] FLAGS_ONE_RESET = 16'h0000;
    localparam logic [15:0] FLAGS_TWO_RESET = 16'h0000;
    localparam logic GLOBAL_EN_RESET = 1'b1;
    localparam logic POLARITY_RESET = 1'b1;
    // receive error counter thresholds
    localparam logic [15:0] RX_ERR_HALF = 16'h7fff;
    localparam logic [15:0] RX_ERR_MAX = 16'hffff;
endpackage : irq_bank_pkg
`default_nettype wire

// ---- pin_sync.sv ----
// two-flop synchroniser for asynchronous event inputs
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic [WIDTH-1:0] D_IN,
    output logic [WIDTH-1:0] Q_OUT
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_state_t;
    sync_state_t s_q;
    sync_state_t s_d;
    // first stage only feeds the second
    always_comb begin
        s_d = s_q;
        s_d.meta = D_IN;
        s_d.sync = s_q.meta;
    end
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign Q_OUT = s_q.sync;
endmodule // pin_sync
`default_nettype wire

// ---- phy_interrupt_status_enable_bank.sv ----
// interrupt flag/enable bank with ahb-lite register slave and interrupt pin
`default_nettype none
module phy_interrupt_status_enable_bank
    import irq_bank_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // ahb-lite slave
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // event sources from the line side (asynchronous levels/pulses)
    input wire logic ENERGY_DETECT_IN,
    input wire logic LINK_STATUS_IN,
    input wire logic WAKE_PACKET_IN,
    input wire logic ESD_EVENT_IN,
    input wire logic TRAINING_DONE_IN,
    input wire logic FALSE_CARRIER_HALF_IN,
    input wire logic RX_ERROR_IN,
    input wire logic LINK_QUALITY_IN,
    // interrupt pin
    output logic IRQ_PIN_OUT
);
    // flags hold bits 6..0 = energy, link, wake, esd, train, fhf, rhf
    typedef struct packed {
        logic [NUM_EVENTS-1:0] flags;
        logic [7:0] enables;
        logic [15:0] reg_two;
        logic global_en;
        logic polarity;
        logic pin_set;
        logic rising_only;
        logic energy_hist;
        logic energy_prev;
        logic link_prev;
        logic wake_prev;
        logic esd_prev;
        logic train_prev;
        logic fhf_prev;
        logic rxe_prev;
        logic [15:0] rx_err_cnt;
        logic ph_valid;
        logic ph_write;
        logic [8:0] ph_idx;
        logic [31:0] rdata;
        logic irq;
    } bank_state_t;

    bank_state_t s_q;
    bank_state_t s_d;
    logic [7:0] ev_sync;
    logic energy_s, link_s, wake_s, esd_s, train_s, fhf_s, rxe_s, lq_s;
    logic [NUM_EVENTS-1:0] events;
    logic addr_take;
    logic [8:0] addr_idx;
    logic [31:0] read_word;
    logic rd_take;
    logic rd_flags_one;
    logic rd_hist;
    logic rd_count;
    logic rx_half_cross;

    // ======================================================
    // input synchronisers: every pin passes two flops
    pin_sync #(
        .WIDTH(8)
    ) u_sync (
        .CLK_IN(CLK_IN),
        .RESET_IN(RESET_IN),
        .D_IN({ENERGY_DETECT_IN, LINK_STATUS_IN, WAKE_PACKET_IN, ESD_EVENT_IN,
               TRAINING_DONE_IN, FALSE_CARRIER_HALF_IN, RX_ERROR_IN, LINK_QUALITY_IN}),
        .Q_OUT(ev_sync)
    );
    assign {energy_s, link_s, wake_s, esd_s, train_s, fhf_s, rxe_s, lq_s} = ev_sync;

    // ======================================================
    // bus decode: single cycle answer, always OKAY
    // hsize is not checked: every register is one whole word
    assign addr_take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    assign addr_idx = HADDR_IN[10:2];
    // clear-on-read acts at the address phase edge, the edge that also
    // captures the read word, so an event landing there is never wiped unseen
    assign rd_take = addr_take && !HWRITE_IN;
    assign rd_flags_one = rd_take && (addr_idx == FLAGS_ONE_IDX);
    assign rd_hist = rd_take && (addr_idx == ENERGY_HIST_IDX);
    assign rd_count = rd_take && (addr_idx == RX_ERR_CNT_IDX);
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = 1'b0;
    assign HRDATA_OUT = s_q.rdata;

    // counter crosses the half mark when going from 7fff to 8000
    assign rx_half_cross = rxe_s && !s_q.rxe_prev && (s_q.rx_err_cnt == RX_ERR_HALF);

    // ======================================================
    // event edge detection on synchronised levels
    always_comb begin
        events = '0;
        if (s_q.rising_only) begin
            events[6] = energy_s && !s_q.energy_prev;
        end else begin
            events[6] = energy_s != s_q.energy_prev;
        end
        events[5] = link_s != s_q.link_prev;
        events[4] = wake_s && !s_q.wake_prev;
        events[3] = esd_s && !s_q.esd_prev;
        events[2] = train_s && !s_q.train_prev;
        events[1] = fhf_s && !s_q.fhf_prev;
        events[0] = rx_half_cross;
    end

    // read mux for the address phase now on the bus; registered into rdata
    always_comb begin
        read_word = 32'h0000_0000;
        case (addr_idx)
            FLAGS_ONE_IDX: read_word[15:0] = {1'b0, s_q.flags, s_q.enables};
            FLAGS_TWO_IDX: read_word[15:0] = s_q.reg_two;
            STATUS_IDX: read_word[PIN_SET_BIT] = s_q.pin_set;
            CONTROL_IDX: begin
                read_word[POLARITY_BIT] = s_q.polarity;
                read_word[GLOBAL_EN_BIT] = s_q.global_en;
            end
            ENERGY_HIST_IDX: read_word[ENERGY_HIST_BIT] = s_q.energy_hist;
            ENERGY_CFG_IDX: read_word[RISING_ONLY_BIT] = s_q.rising_only;
            RX_ERR_CNT_IDX: read_word[15:0] = s_q.rx_err_cnt;
            default: read_word = 32'h0000_0000;
        endcase
    end

    // ======================================================
    // next-state: flags, registers, counter, pin
    always_comb begin
        s_d = s_q;
        s_d.energy_prev = energy_s;
        s_d.link_prev = link_s;
        s_d.wake_prev = wake_s;
        s_d.esd_prev = esd_s;
        s_d.train_prev = train_s;
        s_d.fhf_prev = fhf_s;
        s_d.rxe_prev = rxe_s;
        // history latches each flagged energy event (rising edges only when rising_only is set) until read at 19h
        if (rd_hist) begin
            s_d.energy_hist = 1'b0;
        end
        if (events[6]) begin
            s_d.energy_hist = 1'b1;
        end
        // saturating receive error counter, cleared on read
        // a count landing on the clearing edge survives as the first new count
        if (rd_count) begin
            s_d.rx_err_cnt = 16'h0000;
        end
        if (rxe_s && !s_q.rxe_prev && s_d.rx_err_cnt != RX_ERR_MAX) begin
            s_d.rx_err_cnt = s_d.rx_err_cnt + 16'h0001;
        end
        // clear on read, then set wins so no event is lost
        if (rd_flags_one) begin
            s_d.flags = '0;
            s_d.pin_set = 1'b0;
        end
        s_d.flags = s_d.flags | events;
        // address phase capture
        s_d.ph_valid = addr_take;
        s_d.ph_write = HWRITE_IN;
        s_d.ph_idx = addr_idx;
        s_d.rdata = addr_take && !HWRITE_IN ? read_word : 32'h0000_0000;
        // data phase writes: flag bits are hardware owned
        if (s_q.ph_valid && s_q.ph_write) begin
            case (s_q.ph_idx)
                FLAGS_ONE_IDX: s_d.enables = HWDATA_IN[7:0];
                FLAGS_TWO_IDX: s_d.reg_two[7:0] = HWDATA_IN[7:0];
                CONTROL_IDX: begin
                    s_d.polarity = HWDATA_IN[POLARITY_BIT];
                    s_d.global_en = HWDATA_IN[GLOBAL_EN_BIT];
                end
                ENERGY_CFG_IDX: s_d.rising_only = HWDATA_IN[RISING_ONLY_BIT];
                default: s_d.rising_only = s_d.rising_only;
            endcase
        end
        // link quality level is gated by its enable and global_en only, no flag held
        s_d.irq = s_q.global_en &&
                  (|(s_q.flags & s_q.enables[NUM_EVENTS-1:0]) ||
                   (lq_s && s_q.enables[LINK_QUAL_EN_BIT]));
        // status records the pin going active; the level that lingers for the
        // cycle after the clearing read must not set it again
        if (s_d.irq && !s_q.irq) begin
            s_d.pin_set = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            s_q <= '0;
            s_q.global_en <= GLOBAL_EN_RESET;
            s_q.polarity <= POLARITY_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // pin idles at the polarity level, active at its inverse
    assign IRQ_PIN_OUT = s_q.irq ^ s_q.polarity;

    // ======================================================
    // assertions
    flag_clear_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        rd_flags_one && !(|events) |=> s_q.flags == '0)
        else $error("flags not cleared by read");
    set_wins_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        events[5] |=> s_q.flags[5])
        else $error("link event lost");
    irq_gate_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        !s_q.global_en |=> !s_q.irq)
        else $error("irq despite global disable");
    irq_cause_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        s_q.global_en && |(s_q.flags & s_q.enables[6:0]) |=> s_q.irq)
        else $error("irq missing");
    pin_level_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        IRQ_PIN_OUT == (s_q.polarity ? !s_q.irq : s_q.irq))
        else $error("pin polarity wrong");
    cnt_sat_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        s_q.rx_err_cnt == RX_ERR_MAX && !rd_count
        |=> s_q.rx_err_cnt == RX_ERR_MAX)
        else $error("counter wrapped");
    rhf_set_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        rx_half_cross |=> s_q.flags[0])
        else $error("half-full flag missing");
    pin_set_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        $rose(s_q.irq) |-> s_q.pin_set)
        else $error("pin-set status missing");
    pin_clear_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        rd_flags_one && s_q.irq |=> !s_q.pin_set)
        else $error("pin-set status not cleared");
    read_word_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        rd_flags_one |=> HRDATA_OUT == {16'h0000, 1'b0, $past(s_q.flags), $past(s_q.enables)})
        else $error("flag register read word wrong");
    events_kept_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        |events |=> (s_q.flags & $past(events)) == $past(events))
        else $error("event lost");
    hist_set_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        events[6] |=> s_q.energy_hist)
        else $error("energy history not set");
    hist_clr_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        rd_hist && !events[6] |=> !s_q.energy_hist)
        else $error("energy history not cleared");
    // ======================================================
    // register writes land at the data phase edge
    enables_wr_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        s_q.ph_valid && s_q.ph_write && s_q.ph_idx == FLAGS_ONE_IDX
        |=> s_q.enables == $past(HWDATA_IN[7:0]))
        else $error("enable write lost");
    two_wr_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        s_q.ph_valid && s_q.ph_write && s_q.ph_idx == FLAGS_TWO_IDX
        |=> s_q.reg_two == {8'h00, $past(HWDATA_IN[7:0])})
        else $error("second register write wrong");
    global_wr_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        s_q.ph_valid && s_q.ph_write && s_q.ph_idx == CONTROL_IDX
        |=> s_q.global_en == $past(HWDATA_IN[GLOBAL_EN_BIT]))
        else $error("global enable write lost");
    polarity_wr_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        s_q.ph_valid && s_q.ph_write && s_q.ph_idx == CONTROL_IDX
        |=> s_q.polarity == $past(HWDATA_IN[POLARITY_BIT]))
        else $error("polarity write lost");
    rise_cfg_wr_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        s_q.ph_valid && s_q.ph_write && s_q.ph_idx == ENERGY_CFG_IDX
        |=> s_q.rising_only == $past(HWDATA_IN[RISING_ONLY_BIT]))
        else $error("rising-only select write lost");
    // ======================================================
    // rising-only check and cover points for the main scenarios
    rise_only_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        s_q.rising_only && !energy_s && s_q.energy_prev |-> !events[6])
        else $error("falling edge flagged");
    read_cov_c: cover property (@(posedge CLK_IN) rd_flags_one && |s_q.flags);
    irq_cov_c: cover property (@(posedge CLK_IN) $rose(s_q.irq));
    race_cov_c: cover property (@(posedge CLK_IN) rd_flags_one && |events);
    hist_cov_c: cover property (@(posedge CLK_IN) rd_hist && s_q.energy_hist);
    half_cov_c: cover property (@(posedge CLK_IN) rx_half_cross);
endmodule // phy_interrupt_status_enable_bank
`default_nettype wire

// ---- irq_host.sv ----
// host model: ahb-lite master issuing single word transfers to the bank
`default_nettype none
module irq_host (
    input wire logic clk_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    output logic hsel_out,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================
    // bus idle
    // the one slave is always selected; word transfers only
    assign hsel_out = 1'b1;
    assign hsize_out = 3'b010;
    initial begin
        haddr_out = 32'h0000_0000;
        htrans_out = 2'b00;
        hwrite_out = 1'b0;
        hwdata_out = 32'h0000_0000;
    end
    // ==================================================
    // transfer
    // one single transfer; caller enters just after a rising edge
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        htrans_out <= 2'b10;
        haddr_out <= addr;
        hwrite_out <= wr;
        // no wait count assumed: hold until hready is seen high
        do @(posedge clk_in); while (hready_in !== 1'b1);
        htrans_out <= 2'b00;
        hwdata_out <= wdata;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        rdata = hrdata_in;
    endtask
endmodule // irq_host
`default_nettype wire

// ---- phy_interrupt_status_enable_bank_test.sv ----
// testbench: random and corner-case events against the interrupt bank
`default_nettype none
module phy_interrupt_status_enable_bank_test
    import irq_bank_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, hsel, hwrite, hready, hresp, irq_pin;
    logic [31:0] haddr, hwdata, hrdata, d, a, b, en;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] ev; // energy, link, wake, esd, train, fc, rxerr, quality
    int n_errors, cmp_count, idx;
    // ==================================================
    // design and host
    phy_interrupt_status_enable_bank u_phy_interrupt_status_enable_bank (
        .CLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .ENERGY_DETECT_IN(ev[0]), .LINK_STATUS_IN(ev[1]), .WAKE_PACKET_IN(ev[2]),
        .ESD_EVENT_IN(ev[3]), .TRAINING_DONE_IN(ev[4]), .FALSE_CARRIER_HALF_IN(ev[5]),
        .RX_ERROR_IN(ev[6]), .LINK_QUALITY_IN(ev[7]), .IRQ_PIN_OUT(irq_pin));
    irq_host u_irq_host (
        .clk_in(clk), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
        .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
        .hwdata_out(hwdata));
    // ==================================================
    // helpers
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd(input logic [31:0] addr, output logic [31:0] data);
        u_irq_host.xfer(1'b0, addr, 32'h0, data);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] junk;
        u_irq_host.xfer(1'b1, addr, data, junk);
    endtask
    // levels toggle (each toggle is a change); the rest get a one-cycle pulse
    task automatic pulse(input int i);
        ev[i] <= ~ev[i];
        @(posedge clk);
        if (i > 1) ev[i] <= 1'b0;
    endtask
    // two sync edges plus flag and pin registers, with margin
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ==================================================
    // watchdog: the counter burst dominates at about 66k cycles
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
    // ==================================================
    // main sequence
    initial begin
        rst = 1'b1;
        ev = 8'h00;
        void'($urandom(32'h46c08cdb));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("irq_pin", 32'h1, {31'h0, irq_pin});
        rd(32'h48, d); chk("flags_one", 32'h0, d);
        rd(32'h4c, d); chk("flags_two", 32'h0, d);
        rd(32'h44, d); chk("control", 32'ha, d & 32'ha);
        rd(32'h0f0, d); chk("unmapped", 32'h0, d);
        // flag bits must ignore writes, enables keep them
        wr(32'h48, 32'hffff); rd(32'h48, d); chk("enables", 32'hff, d);
        wr(32'h4c, 32'hffff); rd(32'h4c, d); chk("enables_two", 32'hff, d);
        // every event kind except rx half-full twice, with random enables
        for (int k = 0; k < 12; k++) begin
            idx = k % 6;
            en = $urandom & 32'hff;
            wr(32'h48, en);
            pulse(idx);
            settle();
            chk("irq_pin", {31'h0, ~en[6-idx]}, {31'h0, irq_pin});
            rd(32'h48, d); chk("flag_set", en | (32'h1 << (14 - idx)), d);
            rd(32'h48, d); chk("flag_clr", en, d);
        end
        // pin-set status, then global gate off
        wr(32'h48, 32'h7f);
        pulse(3);
        settle();
        rd(32'h40, d); chk("pin_set", 32'h1, {31'h0, d[7]});
        rd(32'h48, d);
        settle();
        rd(32'h40, d); chk("pin_set_clr", 32'h0, {31'h0, d[7]});
        wr(32'h44, 32'h8);
        pulse(3);
        settle();
        chk("irq_gated", 32'h1, {31'h0, irq_pin});
        rd(32'h48, d); chk("flag_gated", 32'h87f, d);
        // inverted polarity: idles low, high when active
        wr(32'h44, 32'h2);
        settle();
        chk("irq_idle_low", 32'h0, {31'h0, irq_pin});
        pulse(3);
        settle();
        chk("irq_high", 32'h1, {31'h0, irq_pin});
        rd(32'h48, d);
        wr(32'h44, 32'ha);
        // link quality level has no flag, only its enable
        wr(32'h48, 32'h80);
        ev[7] <= 1'b1;
        settle();
        chk("irq_quality", 32'h0, {31'h0, irq_pin});
        ev[7] <= 1'b0;
        settle();
        chk("irq_quality_off", 32'h1, {31'h0, irq_pin});
        // rising-only energy select: energy level is low here
        wr(32'h404, 32'h1);
        wr(32'h48, 32'h40);
        pulse(0);
        settle();
        rd(32'h48, d); chk("energy_rise", 32'h4040, d);
        pulse(0);
        settle();
        rd(32'h48, d); chk("energy_fall", 32'h40, d);
        rd(32'h64, d); chk("energy_hist", 32'h400, d);
        rd(32'h64, d); chk("energy_hist_clr", 32'h0, d);
        // wake event swept across a clearing read: seen exactly once
        for (int dl = 0; dl < 6; dl++) begin
            fork
                begin
                    repeat (dl) @(posedge clk);
                    pulse(2);
                end
                begin
                    rd(32'h48, a);
                    rd(32'h48, b);
                end
            join
            settle();
            rd(32'h48, d);
            chk("wake_once", 32'h1, 32'(a[12]) + 32'(b[12]) + 32'(d[12]));
        end
        // receive error counter up to and across half-full
        wr(32'h48, 32'h01);
        repeat (32767) begin
            pulse(6);
            @(posedge clk);
        end
        settle();
        rd(32'h48, d); chk("rx_below_half", 32'h01, d);
        pulse(6);
        settle();
        chk("irq_rx_half", 32'h0, {31'h0, irq_pin});
        rd(32'h48, d); chk("rx_half", 32'h101, d);
        rd(32'h54, d); chk("rx_count", 32'h8000, d);
        print_verdict();
    end
endmodule // phy_interrupt_status_enable_bank_test
`default_nettype wire
